// [rtl/slot_port_map.svh]
// register offsets, field positions, reset values and counts for the slot program port
// assumes inclusion by bare name from the package user; definitions only
`ifndef SLOT_PORT_MAP_SVH
`define SLOT_PORT_MAP_SVH

`define CTRL_OFFSET        8'h00
`define STATUS_OFFSET      8'h04
`define SHIFT_OFFSET       8'h08
`define CTRL_RESET         32'h0000_0001
`define CTRL_COMPARE_BIT   0
`define STAT_COMPLETE_BIT  0
`define STAT_MATCH_BIT     1
`define STAT_ACK_BIT       2
`define STAT_TXE_BIT       3
`define STAT_RXE_BIT       4
`define STAT_PDN_BIT       5
`define STAT_TXSLOT_LSB    8
`define STAT_RXSLOT_LSB    16
`define STAT_STATUS_LSB    24
`define WORD_BITS          8
`define SHIFT_CNT_W        4
`define SLOT_BITS          8
`define SLOT_CNT_W         9
`define ACK_PULSE_INDEX    9'h003
`define SYNC_PINS          6

`endif

// [rtl/slot_port_pkg.sv]
// types shared by the slot program port
// assumes slot_port_map.svh holds the numeric constants
package slot_port_pkg;
   typedef enum logic [1:0] {ready_for_data, shifting, words_complete} port_state_t;
   typedef logic [7:0] word_t;
   typedef logic [5:0] slot_t;
endpackage

// [rtl/slot_serial_port.sv]
// serial program port and slot timing of one per-channel time slot assigner
// assumes every pin input is asynchronous to core_clk and that core_clk is much faster than
// the host serial clock and the codec bit clock; software reaches the registers over classic Wishbone
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "slot_port_map.svh"

module slot_serial_port (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [7:0]          adr_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic [31:0]         dat_i,
   output logic      [31:0]         dat_o,
   output logic                     ack_o,
   input  wire logic                group_select_1,
   input  wire logic                host_serial_clk,
   input  wire logic                program_word_in,
   input  wire logic                address_word_in,
   input  wire logic [4:0]          hardwired_identity,
   input  wire logic                codec_bit_clock,
   input  wire logic                transmit_frame_sync,
   input  wire logic                receive_frame_sync,
   input  wire logic                program_ack_in,
   output logic                     program_ack_out,
   output logic                     program_ack_oe,
   output logic                     transmit_slot_enable,
   output logic                     receive_slot_enable,
   output logic                     channel_powerdown_n,
   output logic [2:0]               status_bits
);
   import slot_port_pkg::*;

   logic [`SYNC_PINS-1:0]  pins_raw;
   logic [`SYNC_PINS-1:0]  meta_q;
   logic [`SYNC_PINS-1:0]  sync_q;
   logic [`SYNC_PINS-1:0]  prev_q;
   logic [4:0]             ident_meta_q;
   logic [4:0]             ident_q;
   logic                   sel_s;
   logic                   hclk_fall;
   logic                   bclk_rise;
   logic                   fst_s;
   logic                   fsr_s;
   logic                   fst_at_bclk_q;
   logic                   fsr_at_bclk_q;
   logic                   tx_frame_start;
   logic                   rx_frame_start;

   port_state_t            state_q;
   word_t                  prog_q;
   word_t                  addr_q;
   logic [`SHIFT_CNT_W-1:0] count_q;
   logic                   match;

   logic                   compare_en_q;
   logic                   tx_on_q;
   logic                   rx_on_q;
   slot_t                  tx_slot_q;
   slot_t                  rx_slot_q;
   logic                   tx_run_q;
   logic                   rx_run_q;
   logic [`SLOT_CNT_W-1:0] tx_bit_q;
   logic [`SLOT_CNT_W-1:0] rx_bit_q;
   logic                   ack_pend_q;
   logic                   ack_low_q;
   logic                   wb_hit;
   logic [31:0]            read_word;

   // the acknowledge line is wire-ored with the rest of the bank; its level is not needed here
   logic                   ack_line_unused;
   assign ack_line_unused = program_ack_in;

   assign pins_raw = {receive_frame_sync, transmit_frame_sync, codec_bit_clock,
                      address_word_in, program_word_in, host_serial_clk};

   // two sync stages and one edge stage per pin; only the second and third stages feed any logic
   genvar gi;
   generate
      for (gi = 0; gi < `SYNC_PINS; gi = gi + 1) begin : g_sync
         always_ff @(posedge core_clk) begin
            if (rst) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
               prev_q[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= pins_raw[gi];
               sync_q[gi] <= meta_q[gi];
               prev_q[gi] <= sync_q[gi];
            end
         end
      end
   endgenerate

   // select is synchronised on its own so that its drop acts as the port reset
   logic sel_meta_q;
   logic sel_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sel_meta_q   <= 1'b0;
         sel_q        <= 1'b0;
         ident_meta_q <= 5'h00;
         ident_q      <= 5'h00;
      end else begin
         sel_meta_q   <= group_select_1;
         sel_q        <= sel_meta_q;
         ident_meta_q <= hardwired_identity;
         ident_q      <= ident_meta_q;
      end
   end
   assign sel_s = sel_q;

   assign hclk_fall = prev_q[0] & ~sync_q[0];
   assign bclk_rise = ~prev_q[3] & sync_q[3];
   assign fst_s     = sync_q[4];
   assign fsr_s     = sync_q[5];

   // frame syncs are looked at only on bit clock rising edges, as the codec does
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fst_at_bclk_q <= 1'b0;
         fsr_at_bclk_q <= 1'b0;
      end else if (bclk_rise) begin
         fst_at_bclk_q <= fst_s;
         fsr_at_bclk_q <= fsr_s;
      end
   end
   assign tx_frame_start = bclk_rise & fst_s & ~fst_at_bclk_q;
   assign rx_frame_start = bclk_rise & fsr_s & ~fsr_at_bclk_q;

   // compare-off variant takes any selected transfer
   assign match = ~compare_en_q | (addr_q[4:0] == ident_q);

   // serial shift port
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= ready_for_data;
         prog_q  <= 8'h00;
         addr_q  <= 8'h00;
         count_q <= 4'h0;
      end else if (!sel_s) begin
         // dropping select aborts anything pending, which is why the host waits
         state_q <= ready_for_data;
         count_q <= 4'h0;
      end else begin
         case (state_q)
            ready_for_data, shifting: begin
               if (hclk_fall) begin
                  // first bit sent ends in the top position
                  prog_q  <= {prog_q[6:0], sync_q[1]};
                  addr_q  <= {addr_q[6:0], sync_q[2]};
                  count_q <= count_q + 4'h1;
                  state_q <= (count_q == 4'(`WORD_BITS - 1)) ? words_complete : shifting;
               end
            end
            words_complete: begin
               // words held stable until the sync; the whole bank re-arms there
               if (tx_frame_start) begin
                  state_q <= ready_for_data;
                  count_q <= 4'h0;
               end
            end
            default: state_q <= ready_for_data;
         endcase
      end
   end

   logic accept;
   assign accept = sel_s & (state_q == words_complete) & match & tx_frame_start;

   // program registers; mode is {first bit, second bit}
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_on_q             <= 1'b0;
         rx_on_q             <= 1'b0;
         tx_slot_q           <= 6'h00;
         rx_slot_q           <= 6'h00;
         channel_powerdown_n <= 1'b1;
         status_bits         <= 3'h0;
      end else if (accept) begin
         status_bits <= addr_q[7:5];
         case (prog_q[7:6])
            2'b00: begin
               tx_on_q             <= 1'b1;
               rx_on_q             <= 1'b1;
               tx_slot_q           <= prog_q[5:0];
               rx_slot_q           <= prog_q[5:0];
               channel_powerdown_n <= 1'b1;
            end
            2'b01: begin
               tx_on_q             <= 1'b1;
               tx_slot_q           <= prog_q[5:0];
               channel_powerdown_n <= 1'b1;
            end
            2'b10: begin
               rx_on_q             <= 1'b1;
               rx_slot_q           <= prog_q[5:0];
               channel_powerdown_n <= 1'b1;
            end
            default: begin
               tx_on_q             <= 1'b0;
               rx_on_q             <= 1'b0;
               channel_powerdown_n <= 1'b0;
            end
         endcase
      end
   end

   // open-drain acknowledge: pull low three bit clocks into the frame, let go at the next sync
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_pend_q <= 1'b0;
         ack_low_q  <= 1'b0;
      end else begin
         if (tx_frame_start) begin
            ack_low_q  <= 1'b0;
            ack_pend_q <= accept;
         end else if (ack_pend_q && bclk_rise && tx_bit_q == (`ACK_PULSE_INDEX - 9'h001)) begin
            ack_low_q  <= 1'b1;
            ack_pend_q <= 1'b0;
         end
      end
   end

   // bit counters: one count per bit clock rise, slot is the count over eight, restart at each sync edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_bit_q <= 9'h000;
         tx_run_q <= 1'b0;
      end else if (tx_frame_start) begin
         tx_bit_q <= 9'h000;
         tx_run_q <= 1'b1;
      end else if (bclk_rise && tx_run_q) begin
         tx_bit_q <= tx_bit_q + 9'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_bit_q <= 9'h000;
         rx_run_q <= 1'b0;
      end else if (rx_frame_start) begin
         rx_bit_q <= 9'h000;
         rx_run_q <= 1'b1;
      end else if (bclk_rise && rx_run_q) begin
         rx_bit_q <= rx_bit_q + 9'h001;
      end
   end

   // enables stay high for exactly the eight bit clocks of the programmed slot
   logic [`SLOT_CNT_W-1:0] tx_bit_next;
   logic [`SLOT_CNT_W-1:0] rx_bit_next;
   assign tx_bit_next = tx_frame_start ? 9'h000 : tx_bit_q + 9'h001;
   assign rx_bit_next = rx_frame_start ? 9'h000 : rx_bit_q + 9'h001;

   // a program loaded at this sync already rules slot zero, else slot zero would lose its first bit
   logic                   tx_on_now;
   logic                   rx_on_now;
   slot_t                  tx_slot_now;
   slot_t                  rx_slot_now;
   assign tx_on_now   = (accept && prog_q[7:6] != 2'b10) ? ~prog_q[7] : tx_on_q;
   assign rx_on_now   = (accept && prog_q[7:6] != 2'b01) ? ~prog_q[6] : rx_on_q;
   assign tx_slot_now = (accept && !prog_q[7]) ? prog_q[5:0] : tx_slot_q;
   assign rx_slot_now = (accept && !prog_q[6]) ? prog_q[5:0] : rx_slot_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         transmit_slot_enable <= 1'b0;
         receive_slot_enable  <= 1'b0;
      end else if (bclk_rise) begin
         transmit_slot_enable <= tx_on_now & (tx_run_q | tx_frame_start) & (tx_bit_next[8:3] == tx_slot_now);
         receive_slot_enable  <= rx_on_now & (rx_run_q | rx_frame_start) & (rx_bit_next[8:3] == rx_slot_now);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         program_ack_out <= 1'b0;
         program_ack_oe  <= 1'b0;
      end else begin
         program_ack_out <= 1'b0;
         program_ack_oe  <= ack_low_q;
      end
   end

   // wishbone slave: answers every access one cycle after the strobe, unmapped reads as zero
   assign wb_hit = cyc_i & stb_i & ~ack_o;

   always_comb begin
      read_word = 32'h0000_0000;
      if (adr_i == `CTRL_OFFSET) begin
         read_word[`CTRL_COMPARE_BIT] = compare_en_q;
      end else if (adr_i == `STATUS_OFFSET) begin
         read_word[`STAT_COMPLETE_BIT] = (state_q == words_complete);
         read_word[`STAT_MATCH_BIT]    = match;
         read_word[`STAT_ACK_BIT]      = ack_low_q;
         read_word[`STAT_TXE_BIT]      = transmit_slot_enable;
         read_word[`STAT_RXE_BIT]      = receive_slot_enable;
         read_word[`STAT_PDN_BIT]      = ~channel_powerdown_n;
         read_word[`STAT_TXSLOT_LSB +: 6] = tx_slot_q;
         read_word[`STAT_RXSLOT_LSB +: 6] = rx_slot_q;
         read_word[`STAT_STATUS_LSB +: 3] = status_bits;
      end else if (adr_i == `SHIFT_OFFSET) begin
         read_word[3:0]   = count_q;
         read_word[15:8]  = prog_q;
         read_word[23:16] = addr_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= wb_hit;
         dat_o <= (wb_hit && !we_i) ? read_word : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         compare_en_q <= 1'b1;
      end else if (wb_hit && we_i && sel_i[0] && adr_i == `CTRL_OFFSET) begin
         compare_en_q <= dat_i[`CTRL_COMPARE_BIT];
      end
   end

endmodule

// [verification/slot_serial_port_sva.sv]
// assertions on the pins and bus side of slot_serial_port
// assumes codec pins change on core_clk edges; bound from the foot of this file
`timescale 1ns/10ps
module slot_serial_port_sva (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic codec_bit_clock,
   input wire logic transmit_frame_sync,
   input wire logic program_ack_out,
   input wire logic program_ack_oe,
   input wire logic transmit_slot_enable,
   input wire logic receive_slot_enable,
   input wire logic channel_powerdown_n
);
   logic       bc_q;
   logic       fs_q;
   logic [8:0] bit_q;
   // own count of bit clock rises, 0 at the rise that meets the sync edge
   always_ff @(posedge core_clk) begin
      bc_q <= codec_bit_clock;
      if (rst) begin
         bit_q <= 9'h000;
         fs_q <= 1'b0;
      end else if (codec_bit_clock && !bc_q) begin
         fs_q <= transmit_frame_sync;
         bit_q <= (transmit_frame_sync && !fs_q) ? 9'h000 : bit_q + 9'h001;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("bus ack late");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("bus ack too long");
   a_line_drive: assert property (program_ack_oe |-> !program_ack_out) else $error("ack line driven high");
   a_ack_third: assert property ($rose(program_ack_oe) |-> bit_q == 9'h003) else $error("ack not at bit 3");
   a_ack_release: assert property ($fell(program_ack_oe) |-> bit_q == 9'h000) else $error("ack kept");
   a_tx_slot_edge: assert property ($changed(transmit_slot_enable) |-> bit_q[2:0] == 3'h0)
      else $error("tx enable off slot edge");
   a_rx_slot_edge: assert property ($changed(receive_slot_enable) |-> bit_q[2:0] == 3'h0)
      else $error("rx enable off slot edge");
   a_idle_quiet: assert property (!channel_powerdown_n && $past(channel_powerdown_n, 2) == 1'b0
      |-> !transmit_slot_enable && !receive_slot_enable) else $error("idle channel has slots");
   c_ack: cover property ($rose(program_ack_oe));
   c_tx: cover property ($rose(transmit_slot_enable));
   c_idle: cover property ($fell(channel_powerdown_n));
endmodule
bind slot_serial_port slot_serial_port_sva u_slot_serial_port_sva (.core_clk(core_clk), .rst(rst), .cyc_i(cyc_i),
   .stb_i(stb_i), .ack_o(ack_o), .codec_bit_clock(codec_bit_clock), .transmit_frame_sync(transmit_frame_sync),
   .program_ack_out(program_ack_out), .program_ack_oe(program_ack_oe),
   .transmit_slot_enable(transmit_slot_enable), .receive_slot_enable(receive_slot_enable),
   .channel_powerdown_n(channel_powerdown_n));

// [verification/host_port_model.sv]
// host side of the serial program port: group select, serial clock, two data lines
// assumes core_clk paces the pins; the bench resolves the acknowledge line
`timescale 1ns/10ps
module host_port_model (
   input  wire logic core_clk,
   output logic      group_select_1,
   output logic      host_serial_clk,
   output logic      program_word_in,
   output logic      address_word_in
);
   initial begin
      group_select_1 = 1'b0;
      host_serial_clk = 1'b1;
      program_word_in = 1'b0;
      address_word_in = 1'b1;
   end
   // fewer than 8 bits aborts by dropping select, which resets the port
   task automatic send(input logic [7:0] p, input logic [7:0] a, input logic s, input int n);
      int i;
      group_select_1 <= s;
      repeat (10) @(posedge core_clk);
      for (i = 7; i >= 8 - n; i--) begin
         program_word_in <= p[i]; // first bit sent is bit 7
         address_word_in <= a[i];
         host_serial_clk <= 1'b1; // data changes with the rise
         repeat (10) @(posedge core_clk);
         host_serial_clk <= 1'b0;
         repeat (10) @(posedge core_clk);
      end
      host_serial_clk <= 1'b1;
      // no pull on the data lines, so stale bits are left inverted
      program_word_in <= ~program_word_in;
      address_word_in <= ~address_word_in;
      if (n < 8) group_select_1 <= 1'b0;
      repeat (10) @(posedge core_clk);
   endtask
endmodule

// [verification/slot_serial_port_bench.sv]
// self-checking bench for slot_serial_port: Wishbone reads and writes, host programming transfers
// assumes host_port_model drives the serial pins; the checker binds itself
`timescale 1ns/10ps
module slot_serial_port_bench;
   logic        core_clk   = 1'b0;
   logic        rst        = 1'b1;
   logic        cyc_i      = 1'b0;
   logic        stb_i      = 1'b0;
   logic        we_i       = 1'b0;
   logic [7:0]  adr_i      = 8'h00;
   logic [31:0] dat_i      = 32'h0;
   logic [31:0] dat_o, rd;
   logic        ack_o, gs, hclk, pwi, awi, ack_out, ack_oe, tx_en, rx_en, pdn_n;
   logic [2:0]  stat;
   logic [2:0]  eq         = 3'h0;
   logic [5:0]  etx        = 6'h00;
   logic [5:0]  erx        = 6'h00;
   logic        bclk       = 1'b0;
   logic        fsync      = 1'b0;
   logic [3:0]  ph         = 4'h0;
   logic [5:0]  bn         = 6'h00;
   wire         ack_line   = ack_oe ? ack_out : 1'b1;
   int          err_count  = 0;
   int          n_compared = 0;
   always #2 core_clk = ~core_clk;
   // 12-cycle bit clock against the 20-cycle host clock; 64-bit frame
   always @(posedge core_clk) begin
      ph <= (ph == 4'hb) ? 4'h0 : ph + 4'h1;
      if (ph == 4'h5) begin
         bclk <= 1'b1;
         bn <= bn + 6'h01;
         fsync <= (bn == 6'h3f);
      end else if (ph == 4'hb) begin
         bclk <= 1'b0;
      end
   end
   host_port_model u_host_port_model (.core_clk(core_clk), .group_select_1(gs), .host_serial_clk(hclk),
      .program_word_in(pwi), .address_word_in(awi));
   slot_serial_port u_slot_serial_port (.core_clk(core_clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .group_select_1(gs),
      .host_serial_clk(hclk), .program_word_in(pwi), .address_word_in(awi), .hardwired_identity(5'h0a),
      .codec_bit_clock(bclk), .transmit_frame_sync(fsync), .receive_frame_sync(fsync),
      .program_ack_in(ack_line), .program_ack_out(ack_out), .program_ack_oe(ack_oe),
      .transmit_slot_enable(tx_en), .receive_slot_enable(rx_en), .channel_powerdown_n(pdn_n),
      .status_bits(stat));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      for (k = 0; k < 20 && ack_o !== 1'b1; k++) @(posedge core_clk);
      if (k == 20) begin
         err_count++;
         final_report;
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   // w is 0 for the acknowledge line, 1 for the transmit enable, 2 for the receive enable
   task automatic wait_on(input int w, input logic lvl);
      int k;
      for (k = 0; k < 2000 && (w == 2 ? rx_en : (w == 1 ? tx_en : ack_line)) !== lvl; k++) @(posedge core_clk);
      if (k == 2000) begin
         err_count++;
         final_report;
      end
   endtask
   task automatic prog(input logic [1:0] m, input logic [5:0] s, input logic [2:0] q, input logic [4:0] a);
      u_host_port_model.send({m, s}, {q, a}, 1'b1, 8);
      wait_on(0, 1'b0);
      eq = q;
      if (!m[1]) etx = s;
      if (!m[0]) erx = s;
      check(32'(stat), 32'(eq));
      check(32'(pdn_n), 32'(m != 2'b11));
      wb(1'b0, 8'h04, 32'h0);
      if (m != 2'b11) check(32'({rd[21:16], rd[13:8]}), 32'({erx, etx}));
      check(32'({rd[26:24], rd[5]}), 32'({q, m == 2'b11}));
      wait_on(0, 1'b1);
      if (m != 2'b11) begin
         wait_on(1, 1'b0);
         wait_on(1, 1'b1);
         check(32'(bn), 32'(etx) * 32'h8);
         wait_on(2, 1'b0);
         wait_on(2, 1'b1);
         check(32'(bn), 32'(erx) * 32'h8);
      end
   endtask
   // a transfer that must change nothing: no ack over two frames
   task automatic refused(input logic [7:0] a, input logic s, input int n);
      int k;
      int lows;
      lows = 0;
      u_host_port_model.send(8'h05, a, s, n);
      for (k = 0; k < 1600; k++) begin
         @(posedge core_clk);
         lows += int'(ack_line !== 1'b1);
      end
      check(32'(lows), 32'h0);
      check(32'(stat), 32'(eq));
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      wb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0000_0001);
      wb(1'b1, 8'h04, 32'hffff_ffff);
      wb(1'b0, 8'h04, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      $display("test registers finished");
      prog(2'b00, 6'h02, 3'h3, 5'h0a);
      prog(2'b01, 6'h05, 3'h6, 5'h0a);
      prog(2'b10, 6'h07, 3'h1, 5'h0a);
      prog(2'b11, 6'h01, 3'h4, 5'h0a);
      $display("test modes finished");
      refused(8'h6b, 1'b1, 8);
      wb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h006b_0500);
      refused(8'h2a, 1'b0, 8);
      refused(8'h2a, 1'b1, 4);
      $display("test refusals finished");
      wb(1'b1, 8'h00, 32'h0);
      prog(2'b00, 6'h03, 3'h7, 5'h1f);
      $display("test no compare finished");
      final_report;
   end
endmodule
